// file: pkg/sixio_map.svh
// Constants of the six-bit port: file addresses, field positions, reset values.
// Assumes the includer is a module or package on the instruction-cycle clock.
//
// How it works
// - Port reads return live pin levels
// - Direction write-only; reset sets all bits
// - Six pins; upper two bits read zero
// - Pin three never drives
// - Alternate-function pins read as zero
// - Pull-ups, wake on pins 0,1,3, globally
// - Master clear: pull-up on, no wake
// - Direction loaded only by dedicated instruction
// - Direction one floats, zero drives latch
// - Timer config may override pin two direction
// - External counter source forces pin two input
// - Inputs unlatched; output latches hold value
// - Other pins individually programmable direction
// - Status top bit marks wake-caused reset
// - Bit set/clear rewrites all latches from pins
// - Writes end cycle; reads sample its start
`ifndef SIXIO_MAP_SVH
`define SIXIO_MAP_SVH

`define SIXIO_ADDR_STATUS     5'h03
`define SIXIO_ADDR_PORT       5'h06
`define SIXIO_DIR_RESET       6'h3f
`define SIXIO_OPT_RESET       8'hff
`define SIXIO_STATUS_WAKE_BIT 7
`define SIXIO_OPT_WAKE_DIS    7
`define SIXIO_OPT_PULL_DIS    6
`define SIXIO_OPT_TSRC        5
`define SIXIO_PIN_COUNTER     2
`define SIXIO_PIN_INONLY      3
`define SIXIO_WAKE_PINS       6'h0b
`define SIXIO_PIN_COUNT       6

`endif

// file: pkg/sixio_pkg.sv
// Types shared by the six-bit port modules.
// Assumes nothing beyond a SystemVerilog compiler.
package sixio_pkg;
    typedef logic [5:0] sixio_pins_t;
    typedef logic [7:0] sixio_byte_t;
    typedef enum logic [1:0] {
        SIXIO_ACC_NONE,
        SIXIO_ACC_WRITE,
        SIXIO_ACC_BITOP
    } sixio_acc_e;
endpackage

// file: pkg/sixio_ctrl_if.sv
// Carrier between the port top and its pin control logic.
// Assumes both ends run on sys_clk; all values but master_clear_pin_enable are next-cycle values.
`timescale 1ns/100ps
interface sixio_ctrl_if;
    sixio_pkg::sixio_pins_t next_direction;
    sixio_pkg::sixio_byte_t next_option;
    logic                   master_clear_pin_enable;
    sixio_pkg::sixio_pins_t next_oe;
    sixio_pkg::sixio_pins_t next_pullup;
    sixio_pkg::sixio_pins_t wake_mask;

    modport top  (output next_direction, output next_option, output master_clear_pin_enable,
                  input next_oe, input next_pullup, input wake_mask);
    modport ctrl (input next_direction, input next_option, input master_clear_pin_enable,
                  output next_oe, output next_pullup, output wake_mask);
endinterface

// file: logic/sixio_pin_ctrl.sv
// Per-pin driver enable, pull-up and wake selection from direction and options.
// Assumes the caller registers the results on the same edge as its latches.
`timescale 1ns/100ps
`include "sixio_map.svh"
module sixio_pin_ctrl #(
    parameter int PIN_COUNT = `SIXIO_PIN_COUNT
) (
    // Control carrier
    sixio_ctrl_if.ctrl ctl
);
    // Pin roles are tied to fixed positions, so any other count is refused
    if (PIN_COUNT != `SIXIO_PIN_COUNT) begin : g_bad_count
        $error("sixio_pin_ctrl serves exactly six pins");
    end

    wire pull_on   = ~ctl.next_option[`SIXIO_OPT_PULL_DIS];
    wire wake_on   = ~ctl.next_option[`SIXIO_OPT_WAKE_DIS];
    wire ext_count = ctl.next_option[`SIXIO_OPT_TSRC];

    localparam logic [5:0] WAKE_PINS = `SIXIO_WAKE_PINS;

    genvar k;
    generate
        for (k = 0; k < PIN_COUNT; k++) begin : g_pin
            if (k == `SIXIO_PIN_INONLY) begin : g_inonly
                assign ctl.next_oe[k]     = 1'b0;
                assign ctl.next_pullup[k] = pull_on | ctl.master_clear_pin_enable;
                assign ctl.wake_mask[k]   = wake_on & ~ctl.master_clear_pin_enable;
            end else if (k == `SIXIO_PIN_COUNTER) begin : g_counter
                // Timer source on the pin overrides the direction bit
                assign ctl.next_oe[k]     = ~ctl.next_direction[k] & ~ext_count;
                assign ctl.next_pullup[k] = 1'b0;
                assign ctl.wake_mask[k]   = 1'b0;
            end else begin : g_plain
                assign ctl.next_oe[k]     = ~ctl.next_direction[k];
                assign ctl.next_pullup[k] = WAKE_PINS[k] & pull_on;
                assign ctl.wake_mask[k]   = WAKE_PINS[k] & wake_on;
            end
        end
    endgenerate
endmodule

// file: logic/sixio_port.sv
// Six-bit general-purpose port: output latches, direction, options, wake.
// Assumes the CPU issues at most one port access per instruction cycle,
// and that sys_clk is the instruction-cycle clock.
`timescale 1ns/100ps
`include "sixio_map.svh"
module sixio_port #(
    parameter int PIN_COUNT = `SIXIO_PIN_COUNT
) (
    // Clock and reset
    input  wire logic                   sys_clk,
    input  wire logic                   sys_rst,
    input  wire logic                   reset_by_wake,
    // File register access
    input  wire logic [4:0]             file_addr,
    input  wire logic                   file_rd,
    input  wire logic                   file_wr,
    input  wire sixio_pkg::sixio_byte_t file_wdata,
    output sixio_pkg::sixio_byte_t      file_rdata,
    // Dedicated loads from the working register
    input  wire logic                   dir_load,
    input  wire logic                   opt_load,
    input  wire sixio_pkg::sixio_byte_t w_data,
    // Single-bit set and clear on the port
    input  wire logic                   bitop_valid,
    input  wire logic                   bitop_set,
    input  wire logic [2:0]             bitop_sel,
    // Configuration word
    input  wire logic                   master_clear_pin_enable,
    input  wire sixio_pkg::sixio_pins_t alt_func,
    input  wire logic                   sleep_mode,
    // Pins
    input  wire sixio_pkg::sixio_pins_t pin_in,
    output sixio_pkg::sixio_pins_t      pin_out,
    output sixio_pkg::sixio_pins_t      pin_oe,
    output sixio_pkg::sixio_pins_t      pin_pullup_en,
    // Status
    output logic                        wake_event,
    output logic                        wake_reset_flag,
    output sixio_pkg::sixio_byte_t      option_value
);
    // Pin roles are tied to fixed positions, so any other count is refused
    if (PIN_COUNT != `SIXIO_PIN_COUNT) begin : g_bad_count
        $error("sixio_port serves exactly six pins");
    end

    function automatic logic [7:0] sel_mask(input logic [2:0] sel);
        sel_mask = 8'h01 << sel;
    endfunction

    sixio_pkg::sixio_pins_t pin_meta;
    sixio_pkg::sixio_pins_t pin_sync;
    sixio_pkg::sixio_pins_t direction;
    sixio_pkg::sixio_pins_t wake_ref;
    sixio_pkg::sixio_pins_t next_latch;
    sixio_pkg::sixio_pins_t next_direction;
    sixio_pkg::sixio_byte_t next_option;
    sixio_pkg::sixio_byte_t next_rdata;
    sixio_pkg::sixio_acc_e  acc;

    sixio_ctrl_if ctl ();

    sixio_pin_ctrl #(
        .PIN_COUNT (PIN_COUNT)
    ) u_pin_ctrl (
        .ctl (ctl.ctrl)
    );

    // Pins come from outside; the first stage feeds only the second
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            pin_meta <= 6'h00;
            pin_sync <= 6'h00;
        end else begin
            pin_meta <= pin_in;
            pin_sync <= pin_meta;
        end
    end

    // Live pin view as the CPU sees it, sampled in the cycle of the access
    wire [7:0] port_view = {2'b00, pin_sync & ~alt_func};

    wire hit_port   = (file_addr == `SIXIO_ADDR_PORT);
    wire hit_status = (file_addr == `SIXIO_ADDR_STATUS);
    wire port_wr    = file_wr & hit_port;

    // Bit operations read the pins, not the latches, so input pins'
    // latches pick up whatever level is on the pin
    wire [7:0] bitop_word = bitop_set ? (port_view | sel_mask(bitop_sel))
                                      : (port_view & ~sel_mask(bitop_sel));

    assign acc = bitop_valid ? sixio_pkg::SIXIO_ACC_BITOP
               : port_wr     ? sixio_pkg::SIXIO_ACC_WRITE
               :               sixio_pkg::SIXIO_ACC_NONE;

    always_comb begin
        case (acc)
            sixio_pkg::SIXIO_ACC_BITOP: begin
                next_latch = bitop_word[5:0];
            end
            sixio_pkg::SIXIO_ACC_WRITE: begin
                next_latch = file_wdata[5:0];
            end
            default: begin
                next_latch = pin_out;
            end
        endcase
    end

    // Direction is reachable only through the dedicated load, never by address
    assign next_direction = dir_load ? w_data[5:0] : direction;
    assign next_option    = opt_load ? w_data : option_value;

    wire [7:0] status_view = {wake_reset_flag, 7'h00};

    assign next_rdata = !file_rd   ? file_rdata
                      : hit_port   ? port_view
                      : hit_status ? status_view
                      :              8'h00;

    assign ctl.next_direction = next_direction;
    assign ctl.next_option    = next_option;
    assign ctl.master_clear_pin_enable    = master_clear_pin_enable;

    // Latches, direction and drivers all move on the same edge, the end
    // of the instruction cycle in which the write was issued
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            pin_out       <= 6'h00;
            direction     <= `SIXIO_DIR_RESET;
            option_value  <= `SIXIO_OPT_RESET;
            pin_oe        <= 6'h00;
            pin_pullup_en <= 6'h00;
        end else begin
            pin_out       <= next_latch;
            direction     <= next_direction;
            option_value  <= next_option;
            pin_oe        <= ctl.next_oe;
            pin_pullup_en <= ctl.next_pullup;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            file_rdata <= 8'h00;
        end else begin
            file_rdata <= next_rdata;
        end
    end

    // The reset cause is a level held by the reset logic; catching it while
    // reset is asserted is safe because this reset is synchronous
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            wake_reset_flag <= reset_by_wake;
        end else begin
            wake_reset_flag <= wake_reset_flag;
        end
    end

    // Wake compares against the levels last read; reading the port rearms it
    wire port_rd  = file_rd & hit_port;
    wire mismatch = |((pin_sync ^ wake_ref) & ctl.wake_mask);

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            wake_ref   <= 6'h00;
            wake_event <= 1'b0;
        end else begin
            wake_ref   <= port_rd ? pin_sync : wake_ref;
            wake_event <= sleep_mode & mismatch;
        end
    end

    // Read returns pins masked for alternate use, upper bits zero
    a_read_live_pins:
    assert property (@(posedge sys_clk) disable iff (sys_rst)
        (file_rd && hit_port) |=> file_rdata == {2'b00, $past(pin_sync) & $past(alt_func)
                                                 ^ $past(pin_sync)})
    else $error("port read did not return the pin levels");

    a_upper_bits_zero:
    assert property (@(posedge sys_clk) disable iff (sys_rst)
        $past(file_rd && hit_port) |-> file_rdata[7:6] == 2'b00)
    else $error("unimplemented port bits read nonzero");

    a_alt_reads_zero:
    assert property (@(posedge sys_clk) disable iff (sys_rst)
        (file_rd && hit_port && alt_func[0]) |=> !file_rdata[0])
    else $error("alternate function pin read nonzero");

    a_dir_after_reset:
    assert property (@(posedge sys_clk)
        sys_rst |=> (direction == 6'h3f) && (pin_oe == 6'h00))
    else $error("direction not all inputs after reset");

    a_pin3_never_drives:
    assert property (@(posedge sys_clk) disable iff (sys_rst)
        !pin_oe[`SIXIO_PIN_INONLY])
    else $error("input-only pin driven");

    a_dir_load_drives:
    assert property (@(posedge sys_clk) disable iff (sys_rst)
        (dir_load && !w_data[0] && !w_data[5]) |=> pin_oe[0] && pin_oe[5])
    else $error("cleared direction bit did not enable driver");

    a_counter_forced_in:
    assert property (@(posedge sys_clk) disable iff (sys_rst)
        option_value[`SIXIO_OPT_TSRC] |-> !pin_oe[`SIXIO_PIN_COUNTER])
    else $error("counter pin driven while counting external clock");

    a_master_clear_pin_pullup:
    assert property (@(posedge sys_clk) disable iff (sys_rst)
        ($past(master_clear_pin_enable) && !$past(sys_rst)) |-> pin_pullup_en[`SIXIO_PIN_INONLY])
    else $error("master clear pull-up not on");

    a_latch_holds:
    assert property (@(posedge sys_clk) disable iff (sys_rst)
        (!port_wr && !bitop_valid) |=> $stable(pin_out))
    else $error("output latch changed without a write");

    a_dir_only_loaded:
    assert property (@(posedge sys_clk) disable iff (sys_rst)
        !dir_load |=> $stable(direction))
    else $error("direction changed without a dedicated load");

    a_port_write_lands:
    assert property (@(posedge sys_clk) disable iff (sys_rst)
        (port_wr && !bitop_valid) |=> pin_out == $past(file_wdata[5:0]))
    else $error("port write did not reach the latches at cycle end");

    a_bitop_rewrites:
    assert property (@(posedge sys_clk) disable iff (sys_rst)
        (bitop_valid && bitop_set && bitop_sel == 3'h1) |=>
            pin_out == ($past(port_view[5:0]) | 6'h02))
    else $error("bit set did not rewrite latches from pins");

    a_wake_flag_cause:
    assert property (@(posedge sys_clk)
        (sys_rst ##1 !sys_rst) |-> wake_reset_flag == $past(reset_by_wake))
    else $error("wake reset flag does not match reset cause");

    a_no_wake_when_off:
    assert property (@(posedge sys_clk) disable iff (sys_rst)
        (!sleep_mode) |=> !wake_event)
    else $error("wake event outside sleep");
endmodule

// file: verification/sixio_pin_model.sv
// Pin-side model of the board: outside drivers, weak pull-ups, floating lines.
// Assumes the port outputs are registered on sys_clk.
`timescale 1ns/100ps
module sixio_pin_model (
    // Clock
    input  wire logic                   sys_clk,
    // Port side
    input  wire sixio_pkg::sixio_pins_t pin_out,
    input  wire sixio_pkg::sixio_pins_t pin_oe,
    input  wire sixio_pkg::sixio_pins_t pin_pullup_en,
    // Outside drivers
    input  wire sixio_pkg::sixio_pins_t ext_en,
    input  wire sixio_pkg::sixio_pins_t ext_val,
    // Resolved levels
    output sixio_pkg::sixio_pins_t      pin_level
);
    sixio_pkg::sixio_pins_t float_val = 6'h15;

    // Undriven lines wander so a stale value never reads as a match
    always @(posedge sys_clk) float_val <= ~float_val;

    // A strong outside driver beats the port, like a line held low on the board
    always_comb begin
        for (int i = 0; i < 6; i++) begin
            pin_level[i] = ext_en[i] ? ext_val[i] : pin_oe[i] ? pin_out[i] :
                           pin_pullup_en[i] ? 1'b1 : float_val[i];
        end
    end
endmodule

// file: verification/sixio_port_tb_top.sv
// Self-checking bench for the six-bit port.
// Assumes the pin model resolves pin levels from port and outside drivers.
`timescale 1ns/100ps
module sixio_port_tb_top;
    logic sys_clk = 0, sys_rst = 1, reset_by_wake = 0, file_rd = 0, file_wr = 0;
    logic dir_load = 0, opt_load = 0, bitop_valid = 0, bitop_set = 0, master_clear_pin_enable = 0;
    logic sleep_mode = 0;
    logic [4:0] file_addr = 5'h00;
    logic [2:0] bitop_sel = 3'h0;
    sixio_pkg::sixio_byte_t file_wdata = 8'h00, w_data = 8'h00, file_rdata, option_value, rd;
    sixio_pkg::sixio_pins_t alt_func = 6'h00, ext_en = 6'h3f, ext_val = 6'h00;
    sixio_pkg::sixio_pins_t pin_level, pin_out, pin_oe, pin_pullup_en;
    logic wake_event, wake_reset_flag;
    int bad_count = 0, tests_run = 0;

    always #10 sys_clk = ~sys_clk;

    sixio_port i_sixio_port (.sys_clk(sys_clk), .sys_rst(sys_rst),
        .reset_by_wake(reset_by_wake), .file_addr(file_addr), .file_rd(file_rd),
        .file_wr(file_wr), .file_wdata(file_wdata), .file_rdata(file_rdata),
        .dir_load(dir_load), .opt_load(opt_load), .w_data(w_data),
        .bitop_valid(bitop_valid), .bitop_set(bitop_set), .bitop_sel(bitop_sel),
        .master_clear_pin_enable(master_clear_pin_enable), .alt_func(alt_func), .sleep_mode(sleep_mode),
        .pin_in(pin_level), .pin_out(pin_out), .pin_oe(pin_oe),
        .pin_pullup_en(pin_pullup_en), .wake_event(wake_event),
        .wake_reset_flag(wake_reset_flag), .option_value(option_value));

    sixio_pin_model i_sixio_pin_model (.sys_clk(sys_clk), .pin_out(pin_out),
        .pin_oe(pin_oe), .pin_pullup_en(pin_pullup_en), .ext_en(ext_en),
        .ext_val(ext_val), .pin_level(pin_level));

    task automatic test_done();
        if (bad_count == 0 && tests_run > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask

    task automatic do_reset(input logic wake);
        @(posedge sys_clk);
        sys_rst <= 1'b1;
        reset_by_wake <= wake;
        repeat (3) @(posedge sys_clk);
        sys_rst <= 1'b0;
        cyc(1);
    endtask

    // kind 0 file write, 1 file read, 2 direction load, 3 option load
    task automatic req(input int kind, input logic [4:0] addr, input logic [7:0] val);
        @(posedge sys_clk);
        file_addr <= addr;
        file_wdata <= val;
        w_data <= val;
        file_wr <= (kind == 0);
        file_rd <= (kind == 1);
        dir_load <= (kind == 2);
        opt_load <= (kind == 3);
        @(posedge sys_clk);
        {file_wr, file_rd, dir_load, opt_load} <= 4'h0;
        #1 rd = file_rdata;
    endtask

    task automatic t_reset();
        do_reset(1'b1);
        chk(wake_reset_flag, 1);
        req(1, 5'h03, 8'h00); chk(rd, 8'h80);
        chk(option_value, 8'hff); chk(pin_oe, 8'h00);
        req(3, 5'h00, 8'h00); req(2, 5'h00, 8'h00);
        chk(pin_oe, 8'h37);
        do_reset(1'b0);
        chk(wake_reset_flag, 0); chk(pin_oe, 8'h00);
        req(3, 5'h00, 8'h00); cyc(1); chk(pin_oe, 8'h00);
        req(1, 5'h03, 8'h00); chk(rd, 8'h00);
    endtask

    task automatic t_drive();
        ext_en <= 6'h00;
        req(0, 5'h06, 8'h15); req(2, 5'h00, 8'h00);
        chk(pin_oe, 8'h37);
        chk(pin_out, 8'h15);
        cyc(3); req(1, 5'h06, 8'h00); chk(rd, 8'h1d);
        req(0, 5'h06, 8'hea); chk(pin_out, 8'h2a);
        req(0, 5'h07, 8'h01); chk(pin_out, 8'h2a);
        chk(pin_oe, 8'h37);
        req(1, 5'h07, 8'h00); chk(rd, 8'h00);
        req(3, 5'h00, 8'h20); cyc(1); chk(pin_oe, 8'h33);
        req(2, 5'h00, 8'h2f); chk(pin_oe, 8'h10);
        chk(pin_out, 8'h2a);
        ext_en <= 6'h3f;
    endtask

    task automatic t_read();
        ext_val <= 6'h09; req(2, 5'h00, 8'h00); cyc(3);
        req(1, 5'h06, 8'h00); chk(rd, 8'h09);
        @(posedge sys_clk) alt_func <= 6'h01; cyc(1);
        req(1, 5'h06, 8'h00); chk(rd, 8'h08);
        @(posedge sys_clk);
        alt_func <= 6'h00; ext_val <= 6'h30; cyc(3);
        req(1, 5'h06, 8'h00); chk(rd, 8'h30);
    endtask

    task automatic t_bitop();
        logic [2:0] sel [3] = '{3'h1, 3'h0, 3'h6};
        logic [7:0] exp [3] = '{8'h07, 8'h04, 8'h05};
        ext_val <= 6'h05; req(0, 5'h06, 8'h2a); cyc(3);
        for (int i = 0; i < 3; i++) begin
            @(posedge sys_clk);
            bitop_valid <= 1'b1; bitop_set <= (i != 1); bitop_sel <= sel[i];
            @(posedge sys_clk);
            bitop_valid <= 1'b0;
            #1 chk(pin_out, exp[i]);
        end
    endtask

    task automatic t_wake();
        int n;
        req(3, 5'h00, 8'h00); cyc(1); chk(pin_pullup_en, 8'h0b);
        req(3, 5'h00, 8'hc0); cyc(1); chk(pin_pullup_en, 8'h00);
        @(posedge sys_clk) master_clear_pin_enable <= 1'b1; cyc(2); chk(pin_pullup_en, 8'h08);
        req(3, 5'h00, 8'h40); @(posedge sys_clk) sleep_mode <= 1'b1; req(1, 5'h06, 8'h00);
        ext_val <= 6'h1d; cyc(8); chk(wake_event, 0);
        ext_val <= 6'h1c;
        for (n = 0; n < 10 && wake_event !== 1'b1; n++) cyc(1);
        chk(wake_event, 1);
        if (n == 10) test_done();
        @(posedge sys_clk);
        sleep_mode <= 1'b0; master_clear_pin_enable <= 1'b0;
        do_reset(1'b1); chk(wake_reset_flag, 1);
    endtask

    initial begin
        repeat (3) @(posedge sys_clk);
        sys_rst <= 1'b0;
        cyc(1);
        t_reset();
        t_drive();
        t_read();
        t_bitop();
        t_wake();
        test_done();
    end
endmodule
